// ### verilog/alert_mask_map.vh
// Overview of operation
// - one mask command code; a set bit silences alert, status still records
// - output-voltage mask bits 7..1; 0 pulls the alert, 1 ignores
// - output-current mask bits 7..4; 0 pulls the alert, 1 ignores
// - input mask bits 7..3; 0 pulls the alert, 1 ignores the condition
// - temperature mask bits 7..4; 0 pulls the alert, 1 ignores the condition
// - comm/memory/logic mask bits 7..4,1,0; clear enables, set ignores
// - vendor-specific mask bits 7..4; 0 pulls the alert, 1 ignores
// - clear-faults empties latched status except still-present conditions; gone conditions release the alert
`ifndef ALERT_MASK_MAP_VH
`define ALERT_MASK_MAP_VH

// command codes
`define AM_MASK_CMD         8'h1B
`define AM_CLEAR_FAULTS_CMD 8'h03

// paired status codes, index 0 in the low byte
`define AM_CODE_VOUT        8'h7A
`define AM_CODE_IOUT        8'h7B
`define AM_CODE_INPUT       8'h7C
`define AM_CODE_TEMP        8'h7D
`define AM_CODE_COMM        8'h7E
`define AM_CODE_VENDOR      8'h80
`define AM_STATUS_CODES     48'h807E_7D7C_7B7A

// implemented mask bits per register
`define AM_IMPL_VOUT        8'hFE
`define AM_IMPL_IOUT        8'hF0
`define AM_IMPL_INPUT       8'hF8
`define AM_IMPL_TEMP        8'hF0
`define AM_IMPL_COMM        8'hF3
`define AM_IMPL_VENDOR      8'hF0
`define AM_IMPL_BITS        48'hF0F3_F0F8_F0FE

// mask reset value: every condition pulls the alert
`define AM_MASK_RESET       8'h00
`define AM_STATUS_RESET     8'h00

// register count and field layout
`define AM_NUM_REGS         6
`define AM_IDX_W            3

`endif

// ### verilog/mask_status_slice.v
`timescale 1ns/1ps
`include "alert_mask_map.vh"

module mask_status_slice #(
   parameter [7:0] IMPL = 8'hFF
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       write_en,
   input  wire [7:0] write_data,
   input  wire       clear,
   input  wire [7:0] condition,
   output reg  [7:0] mask,
   output reg  [7:0] status,
   output reg        alert
);

   wire [7:0] next_status;

   // set wins over a clear in the same cycle so no event is lost
   assign next_status = (status & {8{~clear}}) | (condition & IMPL);

   always @(posedge clk) begin
      if (rst) begin
         mask   <= `AM_MASK_RESET;
         status <= `AM_STATUS_RESET;
         alert  <= 1'b0;
      end else begin
         if (write_en) begin
            // unimplemented bits read back as zero
            mask <= write_data & IMPL;
         end
         status <= next_status;
         // 0 pulls the alert, 1 ignores; status still records it
         alert  <= |(next_status & ~mask & IMPL);
      end
   end

endmodule // mask_status_slice

// ### verilog/alert_mask_logic.v
`timescale 1ns/1ps
`include "alert_mask_map.vh"

module alert_mask_logic (
   input  wire        SYS_CLK,
   input  wire        RST,
   input  wire        BYTE_VALID,
   input  wire        BYTE_START,
   input  wire [7:0]  BYTE_DATA,
   input  wire        READ_REQ,
   output reg  [7:0]  READ_DATA,
   output reg         READ_VALID,
   output reg         CODE_ERROR,
   input  wire [47:0] CONDITIONS,
   output wire [47:0] LATCHED_STATUS,
   output wire [47:0] MASKS,
   input  wire        ALERT_OUTPUT_PIN_I,
   output wire        ALERT_OUTPUT_PIN_O,
   output wire        ALERT_OUTPUT_PIN_OE_N,
   output reg         ALERT_LINE_SEEN,
   output wire        ALERT_ACTIVE
);

   // one-hot so each state test is a single flop
   localparam [3:0] S_IDLE   = 4'h1;
   localparam [3:0] S_CODE   = 4'h2;
   localparam [3:0] S_DATA   = 4'h4;
   localparam [3:0] S_IGNORE = 4'h8;

   localparam [47:0] impl_bits    = `AM_IMPL_BITS;

   reg  [3:0]            state;
   reg  [3:0]            next_state;
   reg  [`AM_IDX_W-1:0]  sel;
   reg  [`AM_IDX_W-1:0]  next_sel;
   reg                   sel_valid;
   reg                   next_sel_valid;
   reg                   write_pulse;
   reg                   clear_pulse;
   reg                   code_bad;
   reg  [`AM_IDX_W-1:0]  match_idx;
   reg                   match_any;
   reg  [7:0]            read_mux;
   reg  [5:0]            slice_write;
   reg                   pin_meta;
   reg                   pin_sync;
   integer               k;

   wire [5:0]            slice_alert;

   // code lookup and per-register slices
   genvar gi;
   generate
      for (gi = 0; gi < `AM_NUM_REGS; gi = gi + 1) begin : g_reg
         // each slice owns one mask and its status byte
         mask_status_slice #(
            .IMPL (impl_bits[8*gi+7:8*gi])
         ) u_slice (
            .clk        (SYS_CLK),
            .rst        (RST),
            .write_en   (slice_write[gi]),
            .write_data (BYTE_DATA),
            .clear      (clear_pulse),
            .condition  (CONDITIONS[8*gi+7:8*gi]),
            .mask       (MASKS[8*gi+7:8*gi]),
            .status     (LATCHED_STATUS[8*gi+7:8*gi]),
            .alert      (slice_alert[gi])
         );
      end
   endgenerate

   // status code to register index; unknown codes clear match_any
   always @* begin
      match_idx = 3'h0;
      match_any = 1'b1;
      if (BYTE_DATA == `AM_CODE_VOUT) begin
         match_idx = 3'h0;
      end else if (BYTE_DATA == `AM_CODE_IOUT) begin
         match_idx = 3'h1;
      end else if (BYTE_DATA == `AM_CODE_INPUT) begin
         match_idx = 3'h2;
      end else if (BYTE_DATA == `AM_CODE_TEMP) begin
         match_idx = 3'h3;
      end else if (BYTE_DATA == `AM_CODE_COMM) begin
         match_idx = 3'h4;
      end else if (BYTE_DATA == `AM_CODE_VENDOR) begin
         match_idx = 3'h5;
      end else begin
         match_any = 1'b0;
      end
   end

   // one write strobe, to the selected slice only
   always @* begin
      slice_write = 6'h00;
      for (k = 0; k < `AM_NUM_REGS; k = k + 1) begin
         if (write_pulse && sel == k[`AM_IDX_W-1:0]) begin
            slice_write[k] = 1'b1;
         end
      end
   end

   // command byte, then status code, then mask byte
   always @* begin
      next_state     = state;
      next_sel       = sel;
      next_sel_valid = sel_valid;
      write_pulse    = 1'b0;
      clear_pulse    = 1'b0;
      code_bad       = 1'b0;
      if (BYTE_VALID && BYTE_START) begin
         // a new command always restarts the sequence
         if (BYTE_DATA == `AM_MASK_CMD) begin
            next_state = S_CODE;
         end else if (BYTE_DATA == `AM_CLEAR_FAULTS_CMD) begin
            // clear reaches every slice in the same cycle
            clear_pulse = 1'b1;
            next_state  = S_IGNORE;
         end else begin
            next_state = S_IGNORE;
         end
      end else if (BYTE_VALID) begin
         case (state)
            S_CODE: begin
               if (match_any) begin
                  next_sel       = match_idx;
                  next_sel_valid = 1'b1;
                  next_state     = S_DATA;
               end else begin
                  // a bad code drops the selection so reads return zero
                  next_sel_valid = 1'b0;
                  code_bad       = 1'b1;
                  next_state     = S_IGNORE;
               end
            end
            S_DATA: begin
               // one mask byte per command; later bytes are surplus
               write_pulse = 1'b1;
               next_state  = S_IGNORE;
            end
            S_IDLE: begin
               next_state = S_IDLE;
            end
            S_IGNORE: begin
               // surplus bytes of a packet are dropped
               next_state = S_IGNORE;
            end
            default: begin
               // an illegal state code recovers to idle
               next_state = S_IDLE;
            end
         endcase
      end
   end

   // error is a one-cycle pulse, never sticky
   always @(posedge SYS_CLK) begin
      if (RST) begin
         state      <= S_IDLE;
         sel        <= {`AM_IDX_W{1'b0}};
         sel_valid  <= 1'b0;
         CODE_ERROR <= 1'b0;
      end else begin
         state      <= next_state;
         sel        <= next_sel;
         sel_valid  <= next_sel_valid;
         CODE_ERROR <= code_bad;
      end
   end

   // read back the mask picked by the last status code
   always @* begin
      if (!sel_valid) begin
         read_mux = 8'h00;
      end else if (sel == 3'h0) begin
         read_mux = MASKS[7:0];
      end else if (sel == 3'h1) begin
         read_mux = MASKS[15:8];
      end else if (sel == 3'h2) begin
         read_mux = MASKS[23:16];
      end else if (sel == 3'h3) begin
         read_mux = MASKS[31:24];
      end else if (sel == 3'h4) begin
         read_mux = MASKS[39:32];
      end else if (sel == 3'h5) begin
         read_mux = MASKS[47:40];
      end else begin
         read_mux = 8'h00;
      end
   end

   // data holds until the next read, for a slow host
   always @(posedge SYS_CLK) begin
      if (RST) begin
         READ_DATA  <= 8'h00;
         READ_VALID <= 1'b0;
      end else begin
         READ_VALID <= READ_REQ;
         if (READ_REQ) begin
            READ_DATA <= read_mux;
         end
      end
   end

   // open drain: only ever pulls low, enable low while pulling
   assign ALERT_ACTIVE          = |slice_alert;
   // never drives high; the shared line has a pull-up
   assign ALERT_OUTPUT_PIN_O    = 1'b0;
   assign ALERT_OUTPUT_PIN_OE_N = ~ALERT_ACTIVE;

   // shared line may be pulled by other devices, so sense it
   always @(posedge SYS_CLK) begin
      if (RST) begin
         pin_meta        <= 1'b1;
         pin_sync        <= 1'b1;
         ALERT_LINE_SEEN <= 1'b0;
      end else begin
         pin_meta        <= ALERT_OUTPUT_PIN_I;
         pin_sync        <= pin_meta;
         ALERT_LINE_SEEN <= ~pin_sync;
      end
   end

endmodule // alert_mask_logic

// ### testbench/alert_mask_assertions.sv
`timescale 1ns/1ps
`include "alert_mask_map.vh"
module alert_mask_checker (
   input wire        SYS_CLK,
   input wire        RST,
   input wire        BYTE_VALID,
   input wire        BYTE_START,
   input wire [7:0]  BYTE_DATA,
   input wire        READ_REQ,
   input wire        READ_VALID,
   input wire        CODE_ERROR,
   input wire [47:0] CONDITIONS,
   input wire [47:0] LATCHED_STATUS,
   input wire [47:0] MASKS,
   input wire        ALERT_OUTPUT_PIN_I,
   input wire        ALERT_OUTPUT_PIN_O,
   input wire        ALERT_OUTPUT_PIN_OE_N,
   input wire        ALERT_LINE_SEEN,
   input wire        ALERT_ACTIVE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   wire [47:0] ci   = CONDITIONS & `AM_IMPL_BITS;
   wire [47:0] live = ci & ~MASKS;
   wire [47:0] held = LATCHED_STATUS & ~MASKS & `AM_IMPL_BITS;
   sequence s_open(c); BYTE_VALID && BYTE_START && BYTE_DATA == c; endsequence
   sequence s_next(c); BYTE_VALID && !BYTE_START && BYTE_DATA == c; endsequence
   sequence s_wr;
      s_open(8'h1B) ##1 s_next(8'h7B) ##1 BYTE_VALID && !BYTE_START;
   endsequence
   property p_read; READ_REQ |=> READ_VALID; endproperty
   a_read: assert property (p_read) else $error("read late");
   property p_wr; s_wr |=> MASKS[15:8] == ($past(BYTE_DATA) & 8'hF0);
   endproperty
   a_wr: assert property (p_wr) else $error("mask write");
   property p_bad; s_open(8'h1B) ##1 s_next(8'h7F) |=> CODE_ERROR; endproperty
   a_bad: assert property (p_bad) else $error("bad code");
   property p_latch; |ci |=> (LATCHED_STATUS & $past(ci)) == $past(ci);
   endproperty
   a_latch: assert property (p_latch) else $error("status latch");
   property p_pull; |live |=> ALERT_ACTIVE; endproperty
   a_pull: assert property (p_pull) else $error("alert missing");
   property p_quiet; !(|live || |held) |=> !ALERT_ACTIVE; endproperty
   a_quiet: assert property (p_quiet) else $error("alert spurious");
   property p_clr; s_open(8'h03) ##0 CONDITIONS == 48'h0
      |=> LATCHED_STATUS == 48'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear faults");
   property p_pin;
      ALERT_ACTIVE != ALERT_OUTPUT_PIN_OE_N && !ALERT_OUTPUT_PIN_O;
   endproperty
   a_pin: assert property (p_pin) else $error("pin drive");
   property p_seen; !ALERT_OUTPUT_PIN_I |-> ##3 ALERT_LINE_SEEN; endproperty
   a_seen: assert property (p_seen) else $error("line low missed");
   property p_free; ALERT_OUTPUT_PIN_I |-> ##3 !ALERT_LINE_SEEN; endproperty
   a_free: assert property (p_free) else $error("line high missed");
endmodule // alert_mask_checker
bind alert_mask_logic alert_mask_checker chk_u (
   .SYS_CLK(SYS_CLK), .RST(RST), .BYTE_VALID(BYTE_VALID),
   .BYTE_START(BYTE_START), .BYTE_DATA(BYTE_DATA), .READ_REQ(READ_REQ),
   .READ_VALID(READ_VALID), .CODE_ERROR(CODE_ERROR),
   .CONDITIONS(CONDITIONS), .LATCHED_STATUS(LATCHED_STATUS), .MASKS(MASKS),
   .ALERT_OUTPUT_PIN_I(ALERT_OUTPUT_PIN_I),
   .ALERT_OUTPUT_PIN_O(ALERT_OUTPUT_PIN_O),
   .ALERT_OUTPUT_PIN_OE_N(ALERT_OUTPUT_PIN_OE_N),
   .ALERT_LINE_SEEN(ALERT_LINE_SEEN), .ALERT_ACTIVE(ALERT_ACTIVE));

// ### testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire       clk,
   output reg        valid,
   output reg        start,
   output reg  [7:0] data
);
   initial begin
      valid = 1'b0; start = 1'b0; data = 8'h00;
   end
   task put(input s, input [7:0] d); begin
      @(posedge clk); #1; valid = 1'b1; start = s; data = d;
   end endtask
   // released data shows the inverse, never a stale byte
   task write_mask(input [7:0] code, input [7:0] m); begin
      put(1'b1, 8'h1B); put(1'b0, code); put(1'b0, m);
      @(posedge clk); #1; valid = 1'b0; data = ~m;
   end endtask
   task clear; begin
      put(1'b1, 8'h03);
      @(posedge clk); #1; valid = 1'b0; data = 8'hFC;
   end endtask
   // any three-byte packet, for commands the block must ignore
   task frame(input [7:0] c0, input [7:0] c1, input [7:0] c2); begin
      put(1'b1, c0);
      put(1'b0, c1);
      put(1'b0, c2);
      @(posedge clk);
      #1;
      valid = 1'b0;
      data = ~c2;
   end endtask
endmodule // host_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
   reg         SYS_CLK = 1'b0;
   reg         RST = 1'b1;
   reg         READ_REQ = 1'b0;
   reg  [47:0] CONDITIONS = 48'h0;
   wire        bv, bs, rv, pin_o, oe_n, act, seen;
   wire [7:0]  bd, rd;
   wire [47:0] stat, msk;
   wire        pin_i = oe_n ? 1'b1 : pin_o;
   reg  [23:0] rows [0:5];
   integer     num_errors = 0;
   integer     num_checks = 0;
   integer     i;
   always #2.5 SYS_CLK = ~SYS_CLK;
   host_model host_u (.clk(SYS_CLK), .valid(bv), .start(bs), .data(bd));
   alert_mask_logic dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .BYTE_VALID(bv),
      .BYTE_START(bs), .BYTE_DATA(bd), .READ_REQ(READ_REQ),
      .READ_DATA(rd), .READ_VALID(rv), .CODE_ERROR(), .CONDITIONS(CONDITIONS),
      .LATCHED_STATUS(stat), .MASKS(msk), .ALERT_OUTPUT_PIN_I(pin_i),
      .ALERT_OUTPUT_PIN_O(pin_o), .ALERT_OUTPUT_PIN_OE_N(oe_n),
      .ALERT_LINE_SEEN(seen), .ALERT_ACTIVE(act));
   task cmp(input [63:0] nm, input [47:0] e, input [47:0] g); begin
      num_checks = num_checks + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
   end endtask
   task rd_chk(input [7:0] e); begin
      @(posedge SYS_CLK); #1; READ_REQ = 1'b1;
      @(posedge SYS_CLK); #1; READ_REQ = 1'b0;
      cmp("rvalid", 48'h1, {47'h0, rv});
      cmp("rdata", {40'h0, e}, {40'h0, rd});
   end endtask
   task step(input [47:0] c); begin
      @(posedge SYS_CLK); #1; CONDITIONS = c;
   end endtask
   task give_verdict; begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   end endtask
   initial begin
      #100000; num_errors = num_errors + 1; give_verdict;
   end
   initial begin
      rows[0] = 24'h7A_FFFE; rows[1] = 24'h7B_A5A0; rows[2] = 24'h7C_5F58;
      rows[3] = 24'h7D_FFF0; rows[4] = 24'h7E_FFF3; rows[5] = 24'h80_3C30;
      repeat (4) @(posedge SYS_CLK);
      #1; RST = 1'b0;
      cmp("masks", 48'h0, msk);
      cmp("oe_n", 48'h1, {47'h0, oe_n});
      cmp("pin_o", 48'h0, {47'h0, pin_o});
      cmp("seen", 48'h0, {47'h0, seen});
      for (i = 0; i < 6; i = i + 1) begin
         host_u.write_mask(rows[i][23:16], rows[i][15:8]);
         cmp("mask", {40'h0, rows[i][7:0]}, {40'h0, msk[8*i+:8]});
         rd_chk(rows[i][7:0]);
      end
      // masked vout fault is recorded but stays silent
      step(48'h80);
      step(48'h0);
      cmp("status", 48'h80, stat);
      cmp("alert", 48'h0, {47'h0, act});
      step(48'h1000);
      step(48'h1000);
      cmp("alert", 48'h1, {47'h0, act});
      cmp("oe_n", 48'h0, {47'h0, oe_n});
      // clear while the condition persists: set wins
      host_u.clear;
      cmp("status", 48'h1000, stat);
      step(48'h0);
      host_u.clear;
      step(48'h0);
      cmp("status", 48'h0, stat);
      cmp("alert", 48'h0, {47'h0, act});
      host_u.write_mask(8'h7F, 8'h00);
      cmp("masks", 48'h30F3_F058_A0FE, msk);
      rd_chk(8'h00);
      // a foreign command with a valid code must not touch any mask
      host_u.frame(8'h21, 8'h7A, 8'h00);
      cmp("masks", 48'h30F3_F058_A0FE, msk);
      // line sense lags the pin by the two sync flops and one more
      step(48'h1000);
      repeat (4) @(posedge SYS_CLK);
      #1;
      cmp("seen", 48'h1, {47'h0, seen});
      cmp("pin_o", 48'h0, {47'h0, pin_o});
      // mid-run reset returns every register to its reset value
      RST = 1'b1;
      CONDITIONS = 48'h0;
      repeat (2) @(posedge SYS_CLK);
      #1;
      RST = 1'b0;
      cmp("masks", 48'h0, msk);
      cmp("status", 48'h0, stat);
      cmp("oe_n", 48'h1, {47'h0, oe_n});
      cmp("seen", 48'h0, {47'h0, seen});
      cmp("rdata", 48'h0, {40'h0, rd});
      host_u.write_mask(8'h7D, 8'h3C);
      cmp("masks", 48'h0000_3000_0000, msk);
      rd_chk(8'h30);
      give_verdict;
   end
endmodule // tb
